// File: fcac_host.v
`timescale 1ns/1ps
`include "fcac_map.vh"
// ==========================================
// Host controller: drives flash strobes for reads, identifier entry and reset.
module fcac_host #(
  parameter PULSE_CYC = `FCAC_PULSE_CYC // Strobe phase length in clocks.
) (
  input  wire        clk,                    // System clock, 25 MHz.
  input  wire        arst_n,                 // Asynchronous reset, active low.
  input  wire        rd_req,                 // Request array or identifier read.
  input  wire [18:0] rd_addr,                // Read address.
  input  wire        id_req,                 // Request in-system identifier entry.
  input  wire        rst_req,                // Request reset command.
  input  wire        pin_id_req,             // Request pin-method identifier read.
  input  wire [1:0]  pin_id_sel,             // Identifier select for pin method.
  input  wire [2:0]  pin_id_sect,            // Sector for pin method protection read.
  input  wire        timeout_error_flag,     // Status bit from flash, asynchronous.
  output wire        req_ready,              // Host idle and able to take a request.
  output reg         rd_valid,               // Read data valid pulse.
  output reg  [7:0]  rd_data,                // Read data.
  output reg         id_mode,                // Flash believed to be in identifier mode.
  output reg         prot_bit,               // Last protection read said protected.
  output reg  [18:0] fl_addr,                // Flash address pins.
  output reg         id_voltage_address_bit, // High-voltage qualifier on address bit 9.
  output reg         fl_ce_n,                // Flash chip select, active low.
  output reg         fl_we_n,                // Flash write strobe, active low.
  output reg         fl_oe_n,                // Flash output enable, active low.
  output reg  [7:0]  fl_dq_o,                // Data to flash.
  output reg         fl_dq_oe,               // Data output enable, high while driving.
  input  wire [7:0]  fl_dq_i                 // Data from flash.
);
  localparam [5:0] S_IDLE = 6'h01, S_WSET = 6'h02, S_WLOW = 6'h04;
  localparam [5:0] S_WHI  = 6'h08, S_RLOW = 6'h10, S_RHI  = 6'h20;
  reg [5:0]  state_reg;
  reg [7:0]  cnt_reg;
  reg [2:0]  step_reg;
  reg [2:0]  last_reg;
  reg        pinrd_reg;
  reg        err_s1_reg;
  reg        err_s2_reg;
  reg        err_d_reg;
  reg        err_pend_reg;
  reg [7:0]  dq_s1_reg;
  reg [7:0]  dq_s2_reg;
  reg [2:0]  step_next;
  wire [26:0] rom_word;
  wire        cnt_done = (cnt_reg == 8'h00);
  wire        err_rise = err_s2_reg & ~err_d_reg;

  // The table is fed the next step, so its registered word is ready when the write is set up.
  fcac_seq_rom i_fcac_seq_rom (
    .clk    (clk),
    .arst_n (arst_n),
    .idx    (step_next),
    .word   (rom_word)
  );

  // ==========================================
  // Two-flop synchroniser for the asynchronous error flag.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_s1_reg <= 1'b0;
      err_s2_reg <= 1'b0;
    end else begin
      err_s1_reg <= timeout_error_flag;
      err_s2_reg <= err_s1_reg;
    end
  end

  // Edge detector and pending flag for the error. The detector resets to the idle level
  // of the pin, so no false edge follows reset. A flag held high asks for one reset
  // command only, not a stream of them that would lock out every other request.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_d_reg    <= 1'b0;
      err_pend_reg <= 1'b0;
    end else begin
      err_d_reg <= err_s2_reg;
      // A new edge wins over the clear, so an error is never lost.
      if (err_rise) begin
        err_pend_reg <= 1'b1;
      end else if (state_reg == S_IDLE) begin
        err_pend_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // Two flops on the flash data pins. The read phase is stretched by the same
  // two cycles, so the bus has stood still long before the word is taken.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dq_s1_reg <= 8'h00;
      dq_s2_reg <= 8'h00;
    end else begin
      dq_s1_reg <= fl_dq_i;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // ==========================================
  // Next step of a command sequence, with the same priority as the sequencer.
  always @* begin
    step_next = step_reg;
    case (state_reg)
      S_IDLE: begin
        if (rst_req || err_pend_reg) begin
          step_next = 3'h7;
        end else if (id_req) begin
          step_next = 3'h0;
        end
      end
      S_WHI: begin
        if (cnt_done && (step_reg != last_reg)) begin
          step_next = step_reg + 3'h1;
        end
      end
      default: begin
        step_next = step_reg;
      end
    endcase
  end

  assign req_ready = (state_reg == S_IDLE);

  // ==========================================
  // Bus cycle sequencer. Strobes idle high from reset so no write can occur.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= S_IDLE;
      cnt_reg   <= 8'h00;
      step_reg  <= 3'h7;
      last_reg  <= 3'h0;
      pinrd_reg <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= 8'h00;
      id_mode   <= 1'b0;
      prot_bit  <= 1'b0;
      fl_addr   <= 19'h00000;
      id_voltage_address_bit <= 1'b0;
      fl_ce_n   <= 1'b1;
      fl_we_n   <= 1'b1;
      fl_oe_n   <= 1'b1;
      fl_dq_o   <= 8'h00;
      fl_dq_oe  <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      step_reg <= step_next;
      case (state_reg)
        S_IDLE: begin
          if (rst_req || err_pend_reg) begin
            last_reg  <= 3'h7;     // Reset command, address ignored.
            state_reg <= S_WSET;
          end else if (id_req) begin
            last_reg  <= 3'h2;     // Two unlocks then identifier command.
            state_reg <= S_WSET;
          end else if (pin_id_req) begin
            // Bit 6 low, bits 1..0 select, sector on top bits.
            fl_addr   <= {pin_id_sect, 14'h0000, pin_id_sel};
            id_voltage_address_bit <= 1'b1;
            pinrd_reg <= (pin_id_sel == `FCAC_ID_PROT);
            cnt_reg   <= PULSE_CYC[7:0] + `FCAC_SYNC_CYC;
            state_reg <= S_RLOW;
          end else if (rd_req) begin
            fl_addr   <= rd_addr;  // In identifier mode low byte selects code.
            pinrd_reg <= id_mode && (rd_addr[7:0] == `FCAC_ID_PROT);
            cnt_reg   <= PULSE_CYC[7:0] + `FCAC_SYNC_CYC;
            state_reg <= S_RLOW;
          end
        end
        S_WSET: begin
          // ROM word valid now; set address before strobes fall.
          fl_addr   <= rom_word[26:8];
          fl_dq_o   <= rom_word[7:0];
          fl_dq_oe  <= 1'b1;
          // Strobes stay high here: changing address and strobes together would race
          // the flash's address latch.
          fl_oe_n   <= 1'b1;       // Output enable high for a write.
          cnt_reg   <= PULSE_CYC[7:0];
          state_reg <= S_WLOW;
        end
        S_WLOW: begin
          if (cnt_done) begin
            fl_we_n   <= 1'b1;     // Data held stable over this rising edge.
            fl_ce_n   <= 1'b1;
            cnt_reg   <= PULSE_CYC[7:0];
            state_reg <= S_WHI;
          end else begin
            // Strobes low for PULSE_CYC cycles; a zero count would skip the write.
            fl_ce_n <= 1'b0;
            fl_we_n <= 1'b0;
            cnt_reg <= cnt_reg - 8'h01; // Wide pulse, far above glitch limit.
          end
        end
        S_WHI: begin
          if (cnt_done) begin
            fl_dq_oe <= 1'b0;
            if (step_reg == last_reg) begin
              id_mode   <= (last_reg == 3'h2); // Stays until reset command.
              state_reg <= S_IDLE;
            end else begin
              state_reg <= S_WSET;   // The table already fetches the next step.
            end
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        S_RLOW: begin
          fl_dq_oe <= 1'b0;        // Never drive data while reading.
          fl_ce_n  <= 1'b0;
          fl_oe_n  <= 1'b0;
          if (cnt_done) begin
            rd_data  <= dq_s2_reg;
            rd_valid <= 1'b1;
            if (pinrd_reg) begin
              prot_bit <= (dq_s2_reg == `FCAC_PROT_YES);
            end
            fl_oe_n   <= 1'b1;
            fl_ce_n   <= 1'b1;
            cnt_reg   <= PULSE_CYC[7:0];
            state_reg <= S_RHI;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        S_RHI: begin
          id_voltage_address_bit <= 1'b0;
          if (cnt_done) begin
            state_reg <= S_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // fcac_host

// File: fcac_map.vh
`ifndef FCAC_MAP_VH
`define FCAC_MAP_VH
`define FCAC_UNLOCK1_ADDR 19'h00555
`define FCAC_UNLOCK1_DATA 8'hAA
`define FCAC_UNLOCK2_ADDR 19'h002AA
`define FCAC_UNLOCK2_DATA 8'h55
`define FCAC_IDENT_CMD    8'h90
`define FCAC_RESET_CMD    8'hF0
`define FCAC_SECT_MSB     18
`define FCAC_SECT_LSB     16
`define FCAC_ID_MANUF     8'h00
`define FCAC_ID_DEVICE    8'h01
`define FCAC_ID_PROT      8'h02
`define FCAC_ID_CONT      8'h03
`define FCAC_PROT_YES     8'h01
`define FCAC_PULSE_NS     80
`define FCAC_CLK_NS       40
`define FCAC_PULSE_CYC    ((`FCAC_PULSE_NS + `FCAC_CLK_NS - 1) / `FCAC_CLK_NS)
`define FCAC_SYNC_CYC     8'h02
`endif

// File: fcac_seq_rom.v
`timescale 1ns/1ps
`include "fcac_map.vh"
// ==========================================
// Step table for the command sequences; registered output.
module fcac_seq_rom (
  input  wire        clk,    // System clock.
  input  wire        arst_n, // Asynchronous reset, active low.
  input  wire [2:0]  idx,    // Step index.
  output reg  [26:0] word    // Address and data of the step.
);
  // Table is small, so a case statement stands in for a memory array.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      word <= 27'h0000000;
    end else begin
      case (idx)
        3'h0:    word <= {`FCAC_UNLOCK1_ADDR, `FCAC_UNLOCK1_DATA};
        3'h1:    word <= {`FCAC_UNLOCK2_ADDR, `FCAC_UNLOCK2_DATA};
        3'h2:    word <= {`FCAC_UNLOCK1_ADDR, `FCAC_IDENT_CMD};
        default: word <= {19'h00000, `FCAC_RESET_CMD};
      endcase
    end
  end
endmodule // fcac_seq_rom

// File: fcac_host_checker.sv
`timescale 1ns/1ps
// ==========================================
// Pin protocol checks on the flash host.
module fcac_host_checker (
  input wire        clk,                    // Clock.
  input wire        arst_n,                 // Reset.
  input wire        timeout_error_flag,     // Error flag.
  input wire        rd_valid,               // Read valid.
  input wire        id_mode,                // Id mode.
  input wire [18:0] fl_addr,                // Address.
  input wire        id_voltage_address_bit, // Qualifier.
  input wire        fl_ce_n,                // Select.
  input wire        fl_we_n,                // Write.
  input wire        fl_oe_n,                // Output.
  input wire [7:0]  fl_dq_o,                // Data.
  input wire        fl_dq_oe                // Drive.
);
  reg [7:0] wd_reg; // Byte of the last write.
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // The flash takes data at the strobe rise, so keep the byte held while low.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) wd_reg <= 8'h00;
    else if (!fl_we_n) wd_reg <= fl_dq_o;
  end
  sequence s_rst_wr;
    !fl_we_n && !fl_ce_n && fl_dq_oe && fl_dq_o == 8'hF0;
  endsequence
  a_write_qual: assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n) else $error("bad write");
  a_no_fight: assert property (fl_dq_oe |-> fl_oe_n) else $error("drive clash");
  a_we_wide: assert property ($fell(fl_we_n) |-> !fl_we_n [*2]) else $error("short pulse");
  a_pin_id: assert property (id_voltage_address_bit |-> !fl_addr[6] && fl_we_n) else $error("pin id");
  a_reset_idle: assert property ($rose(arst_n) |-> fl_we_n && !id_mode) else $error("reset");
  a_id_enter: assert property ($rose(id_mode) |-> wd_reg == 8'h90) else $error("id entry");
  a_id_leave: assert property ($fell(id_mode) |-> wd_reg == 8'hF0) else $error("id exit");
  a_err_rst: assert property ($rose(timeout_error_flag) |-> ##[1:30] s_rst_wr) else $error("err");
  a_read_owned: assert property (rd_valid |-> !$past(fl_oe_n) && !$past(fl_ce_n) && !fl_dq_oe) else $error("rd");
endmodule // fcac_host_checker

// File: fcac_flash_model.sv
`timescale 1ns/1ps
// ==========================================
// Behavioural flash: identifier modes, protection and reset command.
module fcac_flash_model #(
  parameter [7:0] PROT = 8'hA5, // One protection flag per sector, bit n for sector n.
  parameter [7:0] MID  = 8'hC3, // Arbitrary value.
  parameter [7:0] DID  = 8'h5A, // Arbitrary value.
  parameter [7:0] CID  = 8'hE1  // Arbitrary value.
) (
  input  wire [18:0] addr, // Address.
  input  wire        hv,   // Qualifier.
  input  wire        ce_n, // Select.
  input  wire        we_n, // Write.
  input  wire        oe_n, // Output.
  input  wire [7:0]  din,  // Write data.
  output wire [7:0]  dout  // Read data.
);
  reg [18:0] al;
  reg [1:0]  st;
  reg        idm;
  reg [7:0]  rv, last;
  realtime   tf = 0; // Time the write window opened.
  wire       wr = !ce_n && !we_n && oe_n;
  wire [1:0] s = hv && !addr[6] ? addr[1:0] : addr[7:0] > 3 ? 2'd0 : addr[1:0];
  initial begin st = 0; idm = 0; last = 0; end
  // Address on the later fall, data on the first rise of the strobes.
  always @(posedge wr) begin al = addr; tf = $realtime; end
  always @(negedge wr) begin
    if ($realtime - tf < 5.0) st = st; // Too short to be a write.
    else if (din == 8'hF0) begin idm = 0; st = 0; end
    else if (st == 0 && al == 19'h00555 && din == 8'hAA) st = 1;
    else if (st == 1 && al == 19'h002AA && din == 8'h55) st = 2;
    else if (st == 2 && al == 19'h00555 && din == 8'h90) begin idm = 1; st = 0; end
    else st = 0;
  end
  // Sector flag picked by the top three address bits.
  always @* begin
    if ((hv && !addr[6]) || idm) rv = s == 0 ? MID : s == 1 ? DID : s == 2 ? {7'h0, PROT[addr[18:16]]} : CID;
    else rv = addr[7:0] ^ {5'h00, addr[18:16]};
    if (!oe_n) last = rv;
  end
  // A released bus shows the inverse, so stale data never passes.
  assign dout = (!oe_n && !ce_n) ? rv : ~last;
endmodule // fcac_flash_model

// File: tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH %s %h %h", n, e, g); end end
module tb;
  reg clk = 0, arst_n = 0, rd_req = 0, id_req = 0, rst_req = 0, pin_req = 0, terr = 0;
  reg [18:0] ra = 0;
  reg [1:0]  sel = 0;
  reg [2:0]  sec = 0;
  wire rdy, rv, idm, pb, hv, ce_n, we_n, oe_n, dqe;
  wire [7:0] rd, dqo, dqi;
  wire [18:0] fa;
  integer error_cnt = 0, check_count = 0, cyc = 0, i;
  always #20 clk = ~clk;
  fcac_host i_fcac_host (.clk(clk), .arst_n(arst_n), .rd_req(rd_req), .rd_addr(ra), .id_req(id_req),
    .rst_req(rst_req), .pin_id_req(pin_req), .pin_id_sel(sel), .pin_id_sect(sec), .timeout_error_flag(terr),
    .req_ready(rdy), .rd_valid(rv), .rd_data(rd), .id_mode(idm), .prot_bit(pb), .fl_addr(fa),
    .id_voltage_address_bit(hv), .fl_ce_n(ce_n), .fl_we_n(we_n), .fl_oe_n(oe_n), .fl_dq_o(dqo),
    .fl_dq_oe(dqe), .fl_dq_i(dqi));
  fcac_flash_model i_fcac_flash_model (.addr(fa), .hv(hv), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .din(dqo), .dout(dqi));
  function [7:0] idc(input [1:0] s, input [2:0] c);
    idc = s == 0 ? 8'hC3 : s == 1 ? 8'h5A : s == 2 ? ((8'hA5 >> c) & 8'h01) : 8'hE1;
  endfunction
  // Request on a falling edge, then wait bounded for data or idle.
  task go(input [3:0] k);
    integer n;
    begin
      n = 0;
      while (rdy !== 1'b1 && n < 99) begin @(negedge clk); n++; end
      {pin_req, rst_req, id_req, rd_req} = k;
      @(negedge clk);
      {pin_req, rst_req, id_req, rd_req} = 4'h0;
      while ((k[3] | k[0] ? rv : rdy) !== 1'b1 && n < 99) begin @(negedge clk); n++; end
      if (n >= 99) begin error_cnt++; $display("MISMATCH handshake 1 0"); end
    end
  endtask
  task rda(input [18:0] a, input [7:0] e);
    begin ra = a; go(1); `CHK("rdata", e, rd) end
  endtask
  task t_pin;
    for (i = 0; i < 8; i++) begin
      sel = i; sec = 7 - i; go(8); `CHK("pin", idc(i, 7 - i), rd)
      if (sel == 2) `CHK("pbit", idc(2, sec), pb)
    end
  endtask
  task t_cmd;
    begin
      go(2); `CHK("idm", 1'b1, idm)
      for (i = 0; i < 12; i++) rda({i[2:0], 8'h3C, 6'h0, i[1:0]}, idc(i, i));
      `CHK("prot", 1'b1, pb)
      go(4); `CHK("idm", 1'b0, idm)
      rda(19'h70002, 8'h05);
    end
  endtask
  task t_err;
    begin
      go(2); terr = 1;
      for (i = 0; i < 40 && idm !== 1'b0; i++) @(negedge clk);
      terr = 0; `CHK("err", 1'b0, idm)
      repeat (6) @(negedge clk);
      rda(19'h1FFFF, 8'hFE);
    end
  endtask
  task summarize;
    begin
      if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  always @(posedge clk) begin cyc++; if (cyc == 5000) begin error_cnt++; summarize; end end
  initial begin
    repeat (10) @(negedge clk);
    arst_n = 1;
    rda(19'h4FFFF, 8'hFB); `CHK("idm0", 1'b0, idm)
    t_pin; t_cmd; t_err; summarize;
  end
endmodule // tb
bind fcac_host fcac_host_checker i_fcac_host_checker (.clk(clk), .arst_n(arst_n), .timeout_error_flag(
  timeout_error_flag), .rd_valid(rd_valid), .id_mode(id_mode), .fl_addr(fl_addr), .id_voltage_address_bit(
  id_voltage_address_bit), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_dq_o(fl_dq_o),
  .fl_dq_oe(fl_dq_oe));
